// ===== rtl/mpf_filter.sv
// Multicast port filter: per-port egress and ingress group masks.
// Assumes an AXI4-Lite master on aclk and a switch core feeding one packet
// lookup per cycle; lookups answer one cycle after they are offered.
`timescale 1ns/100ps

module mpf_filter
  import mpf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Ingress check: packet received on this port
  input wire logic ing_valid,
  input wire logic [63:0] ing_addr,
  input wire logic ing_untranslated,
  output logic ing_done,
  output logic ing_blocked,
  // Egress check: packet on the internal virtual bus
  input wire logic egr_valid,
  input wire logic [63:0] egr_addr,
  input wire logic egr_from_this_port,
  input wire logic egr_ingress_blocked,
  output logic egr_done,
  output logic egr_forward
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Control halfword sits in the upper half of its aligned word
  localparam logic [11:0] CTRL_WORD = {MPF_OFF_CTRL[11:2], 2'b00};
  localparam int CTRL_SHIFT = 8 * int'(MPF_OFF_CTRL[1:0]);
  // Word index of a mask register, or 7 when not a mask register
  function automatic logic [2:0] mpf_mask_idx(input logic [11:0] a);
    case (a)
      MPF_OFF_EGR_LO: mpf_mask_idx = 3'h0;
      MPF_OFF_EGR_HI: mpf_mask_idx = 3'h1;
      MPF_OFF_BALL_LO: mpf_mask_idx = 3'h2;
      MPF_OFF_BALL_HI: mpf_mask_idx = 3'h3;
      MPF_OFF_BUT_LO: mpf_mask_idx = 3'h4;
      MPF_OFF_BUT_HI: mpf_mask_idx = 3'h5;
      default: mpf_mask_idx = 3'h7;
    endcase
  endfunction

  // Group number at the index position of a packet address
  function automatic logic [5:0] mpf_group(input logic [63:0] a,
                                           input logic [5:0] pos);
    logic [63:0] s;
    s = a >> pos;
    mpf_group = s[5:0];
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [5:0] count_reg, count_next;
  logic enable_reg, enable_next;
  logic [5:0] index_reg, index_next;
  logic [31:0] blk_cnt_reg, blk_cnt_next;
  logic aw_held_reg, aw_held_next;
  logic [11:0] aw_addr_reg, aw_addr_next;
  logic w_held_reg, w_held_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic rd_src_reg, rd_src_next;
  logic [31:0] rd_word_reg, rd_word_next;
  logic [2:0] rd_idx_reg, rd_idx_next;
  logic ing_done_reg, ing_done_next;
  logic ing_blk_reg, ing_blk_next;
  logic egr_done_reg, egr_done_next;
  logic egr_fwd_reg, egr_fwd_next;

  logic do_write;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic [2:0] ar_idx;
  logic [31:0] bank_rd;
  logic [6*32-1:0] words;
  logic [63:0] egr_mask, ball_mask, but_mask;
  logic [63:0] live_groups;

  // ----------------------------------------------------------------------
  // Mask memory
  // ----------------------------------------------------------------------
  mpf_mask_bank mpf_mask_bank_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .wr_en(do_write),
    .wr_idx(wr_idx),
    .wr_data(w_data_reg),
    .wr_strb(w_strb_reg),
    .rd_idx(rd_idx),
    .rd_data(bank_rd),
    .all_words(words)
  );

  // Low word carries groups 0-31, high word groups 32-63
  assign egr_mask = {words[1*32 +: 32], words[0*32 +: 32]};
  assign ball_mask = {words[3*32 +: 32], words[2*32 +: 32]};
  assign but_mask = {words[5*32 +: 32], words[4*32 +: 32]};

  // Group g is live only with enable set and g <= count field
  always_comb
  begin
    for (int g = 0; g < MPF_GROUPS; g++)
      live_groups[g] = enable_reg && (6'(g) <= count_reg);
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  // Address and data are latched independently; write fires once both held and no write response is pending
  assign s_axi_awready = ce && !aw_held_reg;
  assign s_axi_wready = ce && !w_held_reg;
  assign do_write = ce && aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_idx = mpf_mask_idx(aw_addr_reg);

  always_comb
  begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    count_next = count_reg;
    enable_next = enable_reg;
    index_next = index_reg;
    if (s_axi_awvalid && !aw_held_reg)
    begin
      aw_held_next = 1'b1;
      aw_addr_next = {s_axi_awaddr[11:2], 2'b00};
    end
    if (s_axi_wvalid && !w_held_reg)
    begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = MPF_RESP_OKAY;
      case (aw_addr_reg)
        // Control word: count and enable live in the upper halfword
        CTRL_WORD:
        begin
          if (w_strb_reg[(CTRL_SHIFT + MPF_CNT_LSB) / 8])
            count_next = w_data_reg[CTRL_SHIFT + MPF_CNT_LSB +: MPF_GRP_W];
          if (w_strb_reg[(CTRL_SHIFT + MPF_EN_BIT) / 8])
            enable_next = w_data_reg[CTRL_SHIFT + MPF_EN_BIT];
        end
        MPF_OFF_INDEX:
          if (w_strb_reg[0])
            index_next = w_data_reg[MPF_IDX_LSB +: MPF_GRP_W];
        MPF_OFF_STAT:
          bresp_next = MPF_RESP_OKAY;
        default:
          if (wr_idx == 3'h7)
            bresp_next = MPF_RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  // Both read sources are flops; the bank index is held while rvalid so
  // rdata stands, though a write to that word meanwhile shows through
  assign s_axi_arready = ce && !rvalid_reg;
  assign ar_idx = mpf_mask_idx({s_axi_araddr[11:2], 2'b00});
  assign rd_idx = rvalid_reg ? rd_idx_reg : ar_idx;

  always_comb
  begin
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rd_src_next = rd_src_reg;
    rd_word_next = rd_word_reg;
    rd_idx_next = rd_idx_reg;
    if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next = MPF_RESP_OKAY;
      rd_idx_next = ar_idx;
      rd_src_next = (ar_idx != 3'h7);
      case ({s_axi_araddr[11:2], 2'b00})
        CTRL_WORD:
          rd_word_next = (32'(count_reg) << (CTRL_SHIFT + MPF_CNT_LSB))
            | (32'(enable_reg) << (CTRL_SHIFT + MPF_EN_BIT));
        MPF_OFF_INDEX:
          rd_word_next = 32'(index_reg) << MPF_IDX_LSB;
        MPF_OFF_STAT:
          rd_word_next = blk_cnt_reg;
        default:
        begin
          rd_word_next = MPF_RST_WORD;
          if (ar_idx == 3'h7)
            rresp_next = MPF_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
  end

  assign s_axi_rdata = rd_src_reg ? bank_rd : rd_word_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ----------------------------------------------------------------------
  // Packet lookups
  // ----------------------------------------------------------------------
  // Ingress: block masks judge packets arriving on this port; egress: the
  // receive mask picks packets off the virtual bus for this port.
  always_comb
  begin
    logic [5:0] ig;
    logic [5:0] eg;
    ig = mpf_group(ing_addr, index_reg);
    eg = mpf_group(egr_addr, index_reg);
    ing_done_next = ing_valid;
    ing_blk_next = 1'b0;
    blk_cnt_next = blk_cnt_reg;
    if (ing_valid && live_groups[ig])
    begin
      if (ball_mask[ig])
        ing_blk_next = 1'b1;
      if (ing_untranslated && but_mask[ig])
        ing_blk_next = 1'b1;
    end
    if (ing_blk_next)
      blk_cnt_next = blk_cnt_reg + 32'h0000_0001;
    egr_done_next = egr_valid;
    egr_fwd_next = egr_valid && live_groups[eg] && egr_mask[eg]
      && !egr_from_this_port
      && !egr_ingress_blocked;
  end

  assign ing_done = ing_done_reg;
  assign ing_blocked = ing_blk_reg;
  assign egr_done = egr_done_reg;
  assign egr_forward = egr_fwd_reg;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Clock enable low freezes everything, bus handshakes included
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg <= 6'h00;
      enable_reg <= 1'b0;
      index_reg <= 6'h00;
      blk_cnt_reg <= MPF_RST_WORD;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg <= 1'b0;
      w_data_reg <= MPF_RST_WORD;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= MPF_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= MPF_RESP_OKAY;
      rd_src_reg <= 1'b0;
      rd_word_reg <= MPF_RST_WORD;
      rd_idx_reg <= 3'h0;
      ing_done_reg <= 1'b0;
      ing_blk_reg <= 1'b0;
      egr_done_reg <= 1'b0;
      egr_fwd_reg <= 1'b0;
    end
    else if (ce)
    begin
      count_reg <= count_next;
      enable_reg <= enable_next;
      index_reg <= index_next;
      blk_cnt_reg <= blk_cnt_next;
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rd_src_reg <= rd_src_next;
      rd_word_reg <= rd_word_next;
      rd_idx_reg <= rd_idx_next;
      ing_done_reg <= ing_done_next;
      ing_blk_reg <= ing_blk_next;
      egr_done_reg <= egr_done_next;
      egr_fwd_reg <= egr_fwd_next;
    end
  end
endmodule

// ===== rtl/mpf_pkg.sv
// Package for the multicast port filter: register map, field layout, sizes.
// Assumes a 32-bit AXI4-Lite register bus and a 64-group filter.
package mpf_pkg;
  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int MPF_DATA_W = 32;
  localparam int MPF_ADDR_W = 12;
  localparam int MPF_GROUPS = 64;
  localparam int MPF_GRP_W = 6;
  localparam int MPF_TLP_ADDR_W = 64;
  localparam int MPF_NUM_MASKS = 3;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] MPF_OFF_CTRL = 12'h336;
  localparam logic [11:0] MPF_OFF_INDEX = 12'h338;
  localparam logic [11:0] MPF_OFF_EGR_LO = 12'h340;
  localparam logic [11:0] MPF_OFF_EGR_HI = 12'h344;
  localparam logic [11:0] MPF_OFF_BALL_LO = 12'h348;
  localparam logic [11:0] MPF_OFF_BALL_HI = 12'h34c;
  localparam logic [11:0] MPF_OFF_BUT_LO = 12'h350;
  localparam logic [11:0] MPF_OFF_BUT_HI = 12'h354;
  localparam logic [11:0] MPF_OFF_STAT = 12'h360;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int MPF_CNT_LSB = 0;
  localparam int MPF_EN_BIT = 15;
  localparam int MPF_IDX_LSB = 0;
  localparam logic [31:0] MPF_RST_WORD = 32'h0000_0000;
  localparam logic [1:0] MPF_RESP_OKAY = 2'h0;
  localparam logic [1:0] MPF_RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/mpf_mask_bank.sv
// Mask memory of the multicast port filter: three 64-bit masks as words.
// Assumes one writer and one reader; read data registered one cycle late.
`timescale 1ns/100ps
module mpf_mask_bank
  import mpf_pkg::*;
#(
  parameter int WORDS = 2 * MPF_NUM_MASKS
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  input wire logic [2:0] rd_idx,
  output logic [31:0] rd_data,
  output logic [WORDS*32-1:0] all_words
);
  logic [31:0] mem_reg [WORDS];
  logic [31:0] mem_next [WORDS];
  logic [31:0] rd_reg;
  logic [31:0] rd_next;

  // ----------------------------------------------------------------------
  // Word storage with byte strobes
  // ----------------------------------------------------------------------
  always_comb
  begin
    for (int w = 0; w < WORDS; w++)
    begin
      mem_next[w] = mem_reg[w];
      for (int b = 0; b < 4; b++)
        if (wr_en && wr_idx == 3'(w) && wr_strb[b])
          mem_next[w][b*8 +: 8] = wr_data[b*8 +: 8];
    end
    rd_next = (rd_idx < 3'(WORDS)) ? mem_reg[rd_idx] : MPF_RST_WORD;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int w = 0; w < WORDS; w++)
        mem_reg[w] <= MPF_RST_WORD;
      rd_reg <= MPF_RST_WORD;
    end
    else if (ce)
    begin
      mem_reg <= mem_next;
      rd_reg <= rd_next;
    end
  end

  assign rd_data = rd_reg;

  // Flat view for the filter logic
  genvar g;
  generate
    for (g = 0; g < WORDS; g++)
    begin : gen_flat
      assign all_words[g*32 +: 32] = mem_reg[g];
    end
  endgenerate
endmodule

// ===== verification/mpf_filter_sva.sv
// Checker for the multicast port filter: bus answers and lookup timing.
// Assumes it is bound to mpf_filter and sees only that module's ports.
`timescale 1ns/100ps
module mpf_filter_sva
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ing_valid,
  input wire logic ing_done,
  input wire logic ing_blocked,
  input wire logic egr_valid,
  input wire logic egr_from_this_port,
  input wire logic egr_ingress_blocked,
  input wire logic egr_done,
  input wire logic egr_forward
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Every lookup answers on the next edge, and only then
  a_ing_answer: assert property (ce && ing_valid |=> ing_done)
    else $error("ingress lookup got no answer");
  a_ing_quiet: assert property (ce && !ing_valid |=> !ing_done)
    else $error("ingress answer without a lookup");
  a_egr_answer: assert property (ce && egr_valid |=> egr_done)
    else $error("egress lookup got no answer");
  a_egr_quiet: assert property (ce && !egr_valid |=> !egr_done)
    else $error("egress answer without a lookup");
  // A packet never goes back out the port it came in on
  a_no_echo: assert property (ce && egr_valid && egr_from_this_port
    |=> !egr_forward) else $error("packet echoed to its own port");
  // Ingress-blocked packets are dropped whatever the egress mask says
  a_blocked_drop: assert property (ce && egr_valid
    && egr_ingress_blocked |=> !egr_forward)
    else $error("ingress-blocked packet forwarded");
  a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_read_clear: assert property (ce && s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read answer held too long");
  a_write_clear: assert property (ce && s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("write answer held too long");
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken while answer pending");
  c_blocked: cover property (ing_done && ing_blocked);
  c_forward: cover property (egr_done && egr_forward);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind mpf_filter mpf_filter_sva mpf_filter_sva_inst (.aclk, .aresetn, .ce,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .ing_valid, .ing_done, .ing_blocked,
  .egr_valid, .egr_from_this_port, .egr_ingress_blocked, .egr_done,
  .egr_forward);

// ===== verification/mpf_core_model.sv
// Switch core stand-in: offers lookups to the filter, returns results.
// Assumes the filter answers one cycle after each offer.
`timescale 1ns/100ps
module mpf_core_model
(
  input wire logic aclk,
  output logic ing_valid,
  output logic [63:0] ing_addr,
  output logic ing_untranslated,
  input wire logic ing_done,
  input wire logic ing_blocked,
  output logic egr_valid,
  output logic [63:0] egr_addr,
  output logic egr_from_this_port,
  output logic egr_ingress_blocked,
  input wire logic egr_done,
  input wire logic egr_forward
);
  // ----------------------------------------------------------------
  // Lookup drivers
  // ----------------------------------------------------------------
  // Released lines show the inverse so a stale value never matches
  initial
  begin
    ing_valid = 1'b0;
    ing_addr = '1;
    ing_untranslated = 1'b0;
    egr_valid = 1'b0;
    egr_addr = '1;
    egr_from_this_port = 1'b0;
    egr_ingress_blocked = 1'b0;
  end
  // Received packet; no answer on time gives X
  task automatic ing_look(input logic [63:0] a, input logic u,
    input int gap, output logic blk);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    ing_valid <= 1'b1;
    ing_addr <= a;
    ing_untranslated <= u;
    @(posedge aclk);
    ing_valid <= 1'b0;
    ing_addr <= ~a;
    ing_untranslated <= ~u;
    @(negedge aclk);
    blk = ing_done ? ing_blocked : 1'bx;
  endtask
  // Packet on the virtual bus, with its origin flags
  task automatic egr_look(input logic [63:0] a, input logic s, ib,
    input int gap, output logic fwd);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    egr_valid <= 1'b1;
    egr_addr <= a;
    egr_from_this_port <= s;
    egr_ingress_blocked <= ib;
    @(posedge aclk);
    egr_valid <= 1'b0;
    egr_addr <= ~a;
    egr_from_this_port <= ~s;
    egr_ingress_blocked <= ~ib;
    @(negedge aclk);
    fwd = egr_done ? egr_forward : 1'bx;
  endtask
endmodule

// ===== verification/tb.sv
// Testbench for the multicast port filter: registers and lookups.
// Assumes the core model drives lookups and the bench owns the bus.
`timescale 1ns/100ps
module tb;
  import mpf_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ing_valid, ing_untranslated, ing_done, ing_blocked;
  logic [63:0] ing_addr, egr_addr;
  logic egr_valid, egr_from_this_port, egr_ingress_blocked;
  logic egr_done, egr_forward;
  int error_cnt = 0, tests_run = 0;
  logic [5:0] idx = 6'h00;

  mpf_filter mpf_filter_inst (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ing_valid, .ing_addr, .ing_untranslated, .ing_done, .ing_blocked,
    .egr_valid, .egr_addr, .egr_from_this_port, .egr_ingress_blocked,
    .egr_done, .egr_forward);
  mpf_core_model mpf_core_model_inst (.aclk, .ing_valid, .ing_addr,
    .ing_untranslated, .ing_done, .ing_blocked, .egr_valid, .egr_addr,
    .egr_from_this_port, .egr_ingress_blocked, .egr_done, .egr_forward);

  // ----------------------------------------------------------------
  // Bus and lookup helpers
  // ----------------------------------------------------------------
  always #5 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic aw = 1'b0;
    logic w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (!aw && s_axi_awready)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w && s_axi_bvalid));
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] er);
    logic ar = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (!ar && s_axi_arready)
      begin
        ar = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (!(ar && s_axi_rvalid));
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  // Control word holds count at 21:16 and enable at 31
  task automatic cfg(input logic en, input logic [5:0] cnt, ix);
    wr(MPF_OFF_CTRL, {en, 9'h000, cnt, 16'h0000}, MPF_RESP_OKAY);
    wr(MPF_OFF_INDEX, {26'h0, ix}, MPF_RESP_OKAY);
    idx = ix;
  endtask
  // Group at the index position; ones below it and junk above it
  function automatic logic [63:0] gaddr(input int g);
    return (64'(g) << idx) | ((64'h1 << idx) - 64'h1)
      | (64'hf << (idx + 6'h06));
  endfunction
  task automatic ing(input int g, input logic u, e);
    logic b;
    mpf_core_model_inst.ing_look(gaddr(g), u, 0, b);
    chk("ing_blocked", 32'(b), 32'(e));
  endtask
  task automatic egr(input int g, input logic s, ib, e);
    logic f;
    mpf_core_model_inst.egr_look(gaddr(g), s, ib, g % 3, f);
    chk("egr_forward", 32'(f), 32'(e));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 6; i++)
      rd(MPF_OFF_EGR_LO + 12'(4 * i), MPF_RST_WORD, MPF_RESP_OKAY);
    for (int i = 0; i < 6; i++)
      wr(MPF_OFF_EGR_LO + 12'(4 * i), 32'h5a00_0001 << i, MPF_RESP_OKAY);
    for (int i = 0; i < 6; i++)
      rd(MPF_OFF_EGR_LO + 12'(4 * i), 32'h5a00_0001 << i, MPF_RESP_OKAY);
    // Only byte 1 strobed: the other bytes keep their old contents
    s_axi_wstrb <= 4'h2;
    wr(MPF_OFF_EGR_LO, 32'hffff_ffff, MPF_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(MPF_OFF_EGR_LO, 32'h5a00_ff01, MPF_RESP_OKAY);
    wr(12'h3f0, 32'hffff_ffff, MPF_RESP_SLVERR);
    rd(12'h3f0, 32'h0, MPF_RESP_SLVERR);
    for (int i = 0; i < 6; i++)
      wr(MPF_OFF_EGR_LO + 12'(4 * i), 32'h0, MPF_RESP_OKAY);
    $display("test regs done");
  endtask
  task automatic t_ingress();
    cfg(1'b1, 6'h3f, 6'h0c);
    wr(MPF_OFF_BALL_HI, 32'h0000_0020, MPF_RESP_OKAY);
    ing(37, 1'b0, 1'b1);
    ing(5, 1'b0, 1'b0);
    cfg(1'b1, 6'h24, 6'h0c);
    ing(37, 1'b0, 1'b0);
    cfg(1'b1, 6'h25, 6'h0c);
    ing(37, 1'b1, 1'b1);
    cfg(1'b0, 6'h25, 6'h0c);
    ing(37, 1'b0, 1'b0);
    wr(MPF_OFF_BALL_HI, 32'h0, MPF_RESP_OKAY);
    cfg(1'b1, 6'h3f, 6'h0c);
    wr(MPF_OFF_BUT_LO, 32'h0000_0008, MPF_RESP_OKAY);
    wr(MPF_OFF_BUT_HI, 32'h0000_0001, MPF_RESP_OKAY);
    wr(MPF_OFF_EGR_LO, 32'h0000_0008, MPF_RESP_OKAY);
    ing(3, 1'b1, 1'b1);
    ing(3, 1'b0, 1'b0);
    ing(32, 1'b1, 1'b1);
    egr(3, 1'b0, 1'b0, 1'b1);
    // Control fields read back; status counts the four blocked packets
    rd(MPF_OFF_CTRL, 32'h803f_0000, MPF_RESP_OKAY);
    rd(MPF_OFF_INDEX, 32'h0000_000c, MPF_RESP_OKAY);
    wr(MPF_OFF_STAT, 32'hffff_ffff, MPF_RESP_OKAY);
    rd(MPF_OFF_STAT, 32'h0000_0004, MPF_RESP_OKAY);
    $display("test ingress done");
  endtask
  task automatic t_egress();
    wr(MPF_OFF_EGR_LO, 32'h0000_0200, MPF_RESP_OKAY);
    wr(MPF_OFF_EGR_HI, 32'h8000_0000, MPF_RESP_OKAY);
    egr(9, 1'b0, 1'b0, 1'b1);
    egr(9, 1'b1, 1'b0, 1'b0);
    egr(9, 1'b0, 1'b1, 1'b0);
    egr(10, 1'b0, 1'b0, 1'b0);
    egr(63, 1'b0, 1'b0, 1'b1);
    cfg(1'b1, 6'h3e, 6'h14);
    egr(63, 1'b0, 1'b0, 1'b0);
    egr(9, 1'b0, 1'b0, 1'b1);
    // Clock enable low: the lookup is not taken and no answer comes
    @(posedge aclk);
    ce <= 1'b0;
    egr(9, 1'b0, 1'b0, 1'bx);
    @(posedge aclk);
    ce <= 1'b1;
    egr(9, 1'b0, 1'b0, 1'b1);
    $display("test egress done");
  endtask

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_ingress();
    t_egress();
    summarize();
  end
  // Whole run needs a few hundred cycles; this allows 40000, over a hundred times that
  initial
  begin
    #400000;
    error_cnt++;
    $display("watchdog expired");
    summarize();
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
endmodule
